// ---- hdl/exd_pkg.sv ----
/*
 * Shared types and constants for the exception dispatch unit.
 * Assumes a single core clock; all inputs come from core logic on that clock.
 */
package exd_pkg;
	localparam int unsigned FP_CONDS = 6;
	localparam logic [7:0] VEC_BREAK = 8'h03;
	localparam logic [7:0] VEC_OVF = 8'h04;
	localparam logic [7:0] VEC_RANGE = 8'h05;
	localparam logic [7:0] VEC_GP = 8'h0d;
	localparam logic [7:0] VEC_FPERR = 8'h10;
	localparam logic [7:0] VEC_SIMDFP = 8'h13;
	localparam int unsigned FLAG_IF = 9;
	localparam int unsigned FLAG_OVF = 11;
	localparam int unsigned SLOTS = 6;
	localparam logic [2:0] POPS_SHORT = 3'h3;
	localparam logic [2:0] POPS_LONG = 3'h5;
	localparam logic [1:0] SHIFT_REAL = 2'h2;
	localparam logic [1:0] SHIFT_PROT = 2'h3;
	localparam logic [1:0] SHIFT_LONG = 2'h0;
	localparam logic [15:0] SEL_NULL = 16'h0000;
	typedef enum logic [1:0] {M_REAL, M_PROT, M_LONG} exd_mode_e;
	typedef enum logic [3:0] {K_HW, K_INTN, K_INTO, K_INT3, K_BOUND, K_FPX, K_FPS,
		K_RETURN} exd_kind_e;
	typedef enum logic [1:0] {G_INTR, G_TRAP, G_TASK} exd_gate_e;
	typedef struct packed {
		exd_kind_e kind;
		logic [7:0] vector;
		logic err_valid;
		logic [31:0] err_code;
		logic [FP_CONDS-1:0] fp_cond;
		logic [31:0] bnd_val;
		logic [31:0] bnd_lo;
		logic [31:0] bnd_hi;
	} exd_req_s;
	typedef struct packed {
		logic [63:0] flags;
		logic [15:0] cs;
		logic [63:0] ip;
		logic [15:0] ss;
		logic [63:0] sp;
		logic [1:0] priv;
	} exd_ctx_s;
	typedef struct packed {
		exd_gate_e gtype;
		logic [1:0] tgt_priv;
		logic code64;
		logic [15:0] sel;
		logic [63:0] off;
	} exd_gate_s;
endpackage

// ---- hdl/exd_dispatch.sv ----
/*
 * Exception and interrupt dispatch sequencer: decodes software calls and
 * hardware events to a vector, reads the table entry, builds the stack
 * frame, and hands the handler entry point to the core.
 * Assumes table, stack and task-switch partners on the same clock.
 */
`timescale 1ns/1ps
module exd_dispatch (
	input wire logic clk, // Core clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic req_valid, // Event or instruction request
	input exd_pkg::exd_req_s req, // Request contents
	input exd_pkg::exd_mode_e mode, // Operating mode
	input exd_pkg::exd_ctx_s ctx, // Interrupted context
	output logic busy_q, // Sequence in progress
	output logic tbl_req_q, // Table read strobe
	output logic [15:0] tbl_addr_q, // Table byte address
	input wire logic tbl_valid, // Table entry returned
	input exd_pkg::exd_gate_s tbl_entry, // Table entry
	output logic push_valid_q, // Stack push valid
	output logic [63:0] push_data_q, // Stack push data
	output logic push_wide_q, // 8-byte push
	input wire logic push_ready, // Stack accepts push
	output logic pop_req_q, // Stack pop strobe
	input wire logic pop_valid, // Pop data valid
	input wire logic [63:0] pop_data, // Popped word
	output logic task_save_q, // Save task state strobe
	output logic task_restore_q, // Restore task state strobe
	output logic [15:0] task_sel_q, // Handler task selector
	input wire logic task_ack, // Task switch done
	output logic jump_q, // Handler entry pulse
	output logic resume_q, // Return to interrupted code pulse
	output logic [7:0] vector_q, // Dispatched vector
	output logic [15:0] new_cs_q, // New code selector
	output logic [63:0] new_ip_q, // New instruction pointer
	output logic [63:0] new_flags_q, // New flags register
	output logic ss_null_q, // Stack selector loaded null
	output logic [15:0] new_ss_q // New stack selector
);
	import exd_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_TBL, S_PUSH, S_TASK, S_POP, S_RTASK} exd_state_e;

	////////////////////////////////////////////////////////////////////////
	// Request decode
	exd_state_e state_q;
	exd_mode_e mode_q;
	exd_ctx_s ctx_q;
	logic [31:0] err_q;
	logic err_v_q;
	logic task_q;
	logic [5:0] mask_q;
	logic [2:0] idx_q;
	logic [2:0] pops_q;
	exd_gate_s gate_q;

	wire accept = req_valid && (state_q == S_IDLE);
	wire ovf = ctx.flags[FLAG_OVF];
	wire outside = (req.bnd_val < req.bnd_lo) || (req.bnd_val > req.bnd_hi);
	wire fp_any = |req.fp_cond;
	// Only listed kinds can raise a vector; overflow flag alone never does
	wire fire = (req.kind == K_HW) || (req.kind == K_INTN) ||
		(req.kind == K_INT3) ||
		(req.kind == K_INTO && ovf) ||
		(req.kind == K_BOUND && outside) ||
		((req.kind == K_FPX || req.kind == K_FPS) && fp_any);
	// Vector selection; generic call keeps operand, so 4 and 5 match
	wire [7:0] vec_d = (req.kind == K_INT3) ? VEC_BREAK :
		(req.kind == K_INTO) ? VEC_OVF :
		(req.kind == K_BOUND) ? VEC_RANGE :
		(req.kind == K_FPX) ? VEC_FPERR :
		(req.kind == K_FPS) ? VEC_SIMDFP : req.vector;
	// Table stride: 4 bytes real, 8 protected, 16 long
	wire [1:0] shf = (mode == M_REAL) ? SHIFT_REAL :
		(mode == M_PROT) ? SHIFT_PROT : SHIFT_LONG;
	wire [15:0] addr_d = (mode == M_LONG) ? {4'h0, vec_d, 4'h0} : (16'(vec_d) << shf);

	////////////////////////////////////////////////////////////////////////
	// Table entry evaluation
	wire real_m = (mode_q == M_REAL);
	wire long_m = (mode_q == M_LONG);
	wire priv_chg = !real_m && (tbl_entry.tgt_priv != ctx_q.priv);
	wire stk_push = long_m || priv_chg;
	wire bad64 = long_m && !tbl_entry.code64 && (vector_q != VEC_GP);
	wire is_task = !real_m && (tbl_entry.gtype == G_TASK);
	wire clr_if = real_m || (tbl_entry.gtype == G_INTR);

	// Frame slot contents in push order
	function automatic logic [63:0] slot(input logic [2:0] i, input exd_ctx_s c,
		input logic [31:0] e);
		case (i)
			3'd0: slot = {48'h0000_0000_0000, c.ss};
			3'd1: slot = c.sp;
			3'd2: slot = c.flags;
			3'd3: slot = {48'h0000_0000_0000, c.cs};
			3'd4: slot = c.ip;
			default: slot = {32'h0000_0000, e};
		endcase
	endfunction

	wire [63:0] slot_w = slot(idx_q, ctx_q, err_q);
	wire [63:0] slot_z = long_m ? slot_w : {32'h0000_0000, slot_w[31:0]};
	wire [63:0] flags_clr = ctx_q.flags & ~(64'h1 << FLAG_IF);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			mode_q <= M_REAL;
			ctx_q <= '0;
			err_q <= 32'h0000_0000;
			err_v_q <= 1'b0;
			task_q <= 1'b0;
			mask_q <= 6'h00;
			idx_q <= 3'h0;
			pops_q <= 3'h0;
			gate_q <= '0;
			busy_q <= 1'b0;
			tbl_req_q <= 1'b0;
			tbl_addr_q <= 16'h0000;
			push_valid_q <= 1'b0;
			push_data_q <= 64'h0000_0000_0000_0000;
			push_wide_q <= 1'b0;
			pop_req_q <= 1'b0;
			task_save_q <= 1'b0;
			task_restore_q <= 1'b0;
			task_sel_q <= 16'h0000;
			jump_q <= 1'b0;
			resume_q <= 1'b0;
			vector_q <= 8'h00;
			new_cs_q <= 16'h0000;
			new_ip_q <= 64'h0000_0000_0000_0000;
			new_flags_q <= 64'h0000_0000_0000_0000;
			ss_null_q <= 1'b0;
			new_ss_q <= 16'h0000;
		end else begin
			tbl_req_q <= 1'b0;
			pop_req_q <= 1'b0;
			task_save_q <= 1'b0;
			task_restore_q <= 1'b0;
			jump_q <= 1'b0;
			resume_q <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (accept && req.kind == K_RETURN) begin
						mode_q <= mode;
						busy_q <= 1'b1;
						if (task_q) begin
							task_restore_q <= 1'b1;
							state_q <= S_RTASK;
						end else begin
							pops_q <= (mode == M_LONG) ? POPS_LONG : POPS_SHORT;
							pop_req_q <= 1'b1;
							state_q <= S_POP;
						end
					end else if (accept && fire) begin
						mode_q <= mode;
						ctx_q <= ctx;
						err_q <= req.err_code;
						err_v_q <= req.err_valid;
						vector_q <= vec_d;
						tbl_addr_q <= addr_d;
						tbl_req_q <= 1'b1;
						busy_q <= 1'b1;
						state_q <= S_TBL;
					end
				end
				S_TBL: begin
					if (tbl_valid && bad64) begin
						// Non-64-bit target: redirect to protection fault
						vector_q <= VEC_GP;
						tbl_addr_q <= {4'h0, VEC_GP, 4'h0};
						tbl_req_q <= 1'b1;
						err_v_q <= 1'b1;
						err_q <= {16'h0000, tbl_entry.sel};
					end else if (tbl_valid && is_task) begin
						task_sel_q <= tbl_entry.sel;
						task_save_q <= 1'b1;
						state_q <= S_TASK;
					end else if (tbl_valid) begin
						gate_q <= tbl_entry;
						// Slots: stack pair, flags, cs, ip, error
						mask_q <= {err_v_q, 3'b111, stk_push, stk_push};
						new_flags_q <= clr_if ? flags_clr : ctx_q.flags;
						ss_null_q <= long_m && priv_chg;
						new_ss_q <= (long_m && priv_chg) ? SEL_NULL : ctx_q.ss;
						idx_q <= 3'h0;
						state_q <= S_PUSH;
					end
				end
				S_PUSH: begin
					if (push_valid_q && !push_ready) begin
						push_valid_q <= 1'b1;
					end else if (idx_q == 3'(SLOTS)) begin
						push_valid_q <= 1'b0;
						// Real mode entry is a bare pointer pair
						new_cs_q <= real_m ? gate_q.off[31:16] : gate_q.sel;
						new_ip_q <= real_m ? {48'h0000_0000_0000, gate_q.off[15:0]} :
							gate_q.off;
						jump_q <= 1'b1;
						busy_q <= 1'b0;
						state_q <= S_IDLE;
					end else begin
						push_valid_q <= mask_q[idx_q];
						push_data_q <= slot_z;
						push_wide_q <= long_m;
						idx_q <= idx_q + 3'h1;
					end
				end
				S_TASK: begin
					if (task_ack) begin
						task_q <= 1'b1;
						jump_q <= 1'b1;
						busy_q <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				S_RTASK: begin
					if (task_ack) begin
						task_q <= 1'b0;
						resume_q <= 1'b1;
						busy_q <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				S_POP: begin
					// Pops come back as ip, cs, flags; long mode pops ip and cs twice, then flags
					if (pop_valid) begin
						case (pops_q)
							3'h5, 3'h3: new_ip_q <= pop_data;
							3'h4: new_cs_q <= pop_data[15:0];
							3'h2: new_cs_q <= pop_data[15:0];
							default: new_flags_q <= pop_data;
						endcase
						if (pops_q == 3'h1) begin
							resume_q <= 1'b1;
							busy_q <= 1'b0;
							state_q <= S_IDLE;
						end else begin
							pops_q <= pops_q - 3'h1;
							pop_req_q <= 1'b1;
						end
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence into_clear_s;
		accept && req.kind == K_INTO && !ovf;
	endsequence
	sequence into_set_s;
		accept && req.kind == K_INTO && ovf;
	endsequence
	// Table entry taken for a frame build, not a redirect or a task switch
	sequence gate_taken_s;
		state_q == S_TBL && tbl_valid && !bad64 && !is_task;
	endsequence

	into_quiet_a: assert property (into_clear_s |=> !tbl_req_q && !busy_q)
		else $error("overflow call fired with flag clear");
	into_vec_a: assert property (into_set_s |=> tbl_req_q && vector_q == VEC_OVF)
		else $error("overflow call did not reach vector 4");
	intn_vec_a: assert property (
		accept && req.kind == K_INTN |=> vector_q == $past(req.vector))
		else $error("generic call vector altered");
	brk_vec_a: assert property (
		accept && req.kind == K_INT3 |=> tbl_req_q && vector_q == VEC_BREAK)
		else $error("breakpoint not dispatched to vector 3");
	bound_in_a: assert property (
		accept && req.kind == K_BOUND && !outside |=> !busy_q)
		else $error("bounds check fired inside limits");
	fp_route_a: assert property (
		accept && req.kind == K_FPS && fp_any |=> vector_q == VEC_SIMDFP)
		else $error("packed float fault not on vector 19");
	fpx_route_a: assert property (
		accept && req.kind == K_FPX && fp_any |=> vector_q == VEC_FPERR)
		else $error("legacy float fault not on vector 16");
	push_wide_a: assert property (push_valid_q && mode_q == M_LONG |-> push_wide_q)
		else $error("long mode push not 8 bytes");
	real_addr_a: assert property (
		tbl_req_q && mode_q == M_REAL |-> tbl_addr_q == {6'h00, vector_q, 2'h0})
		else $error("real mode table index wrong");
	task_save_a: assert property (
		state_q == S_TBL && tbl_valid && is_task && !bad64 |=> task_save_q ##1 !jump_q)
		else $error("task gate did not save state first");
	ss_null_a: assert property (
		jump_q && ss_null_q |-> new_ss_q == SEL_NULL && mode_q == M_LONG)
		else $error("null stack selector not loaded");
	// Frame build checks
	push_zext_a: assert property (
		push_valid_q && mode_q != M_LONG |-> push_data_q[63:32] == 32'h0000_0000)
		else $error("short mode push not zero extended");
	long_stack_a: assert property (
		(gate_taken_s ##0 long_m) |=> mask_q[1:0] == 2'b11)
		else $error("long mode frame lacks stack pair");
	intr_clear_a: assert property (
		(gate_taken_s ##0 clr_if) |=> !new_flags_q[FLAG_IF])
		else $error("interrupt gate left enable set");
endmodule

// ---- verif/exd_dispatch_bench.sv ----
/*
 * Self-checking bench for the exception dispatch sequencer.
 * Assumes the bench answers table reads, stack pushes and pops, and task switches.
 */
`timescale 1ns/1ps
module exd_dispatch_bench;
	import exd_pkg::*;
	localparam logic [63:0] FL = 64'h0000_0001_0000_0a02;
	localparam logic [63:0] IP = 64'hffff_0000_1234_5678;
	localparam logic [63:0] SP = 64'hffff_8000_0000_0100;
	localparam logic [63:0] CS = 64'h0000_0000_0000_0008;
	localparam logic [63:0] SS = 64'h0000_0000_0000_0010;
	logic clk, nrst, req_valid, busy_q, tbl_req_q, tbl_valid, push_valid_q, push_wide_q;
	logic push_ready, pop_req_q, pop_valid, task_save_q, task_restore_q, task_ack;
	logic jump_q, resume_q, ss_null_q, tv, pv, av, stall, wide;
	logic [15:0] tbl_addr_q, task_sel_q, new_cs_q, new_ss_q, ta;
	logic [63:0] push_data_q, pop_data, new_ip_q, new_flags_q;
	logic [7:0] vector_q;
	logic [63:0] pushes[$], ex[$], pq[$];
	exd_req_s req;
	exd_mode_e mode;
	exd_ctx_s ctx;
	exd_gate_s tbl_entry, ent;
	int miscompares, check_count, tcnt, pops, ts, tr;
	////////////////////////////////////////////////////////////
	exd_dispatch i_exd_dispatch (.clk, .nrst, .req_valid, .req, .mode, .ctx, .busy_q,
		.tbl_req_q, .tbl_addr_q, .tbl_valid, .tbl_entry, .push_valid_q, .push_data_q,
		.push_wide_q, .push_ready, .pop_req_q, .pop_valid, .pop_data, .task_save_q,
		.task_restore_q, .task_sel_q, .task_ack, .jump_q, .resume_q, .vector_q, .new_cs_q,
		.new_ip_q, .new_flags_q, .ss_null_q, .new_ss_q);
	// Clock of 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Far side stand-in: answers two cycles after each strobe, scrambles idle data
	always @(negedge clk) begin
		tv <= tbl_req_q;
		tbl_valid <= tv;
		tbl_entry <= tv ? ent : exd_gate_s'(~ent);
		av <= task_save_q | task_restore_q;
		task_ack <= av;
		pv <= pop_req_q;
		pop_valid <= pv;
		pop_data <= pv ? pq.pop_front() : ~pop_data;
		push_ready <= stall ? ~push_ready : 1'b1;
	end
	// Records strobes and accepted pushes at the sampling edge
	always @(posedge clk) begin
		if (tbl_req_q === 1'b1) begin
			tcnt++;
			ta = tbl_addr_q;
		end
		if (task_save_q === 1'b1) ts++;
		if (task_restore_q === 1'b1) tr++;
		if (pop_valid) pops++;
		if (push_valid_q === 1'b1 && push_ready) begin
			pushes.push_back(push_data_q);
			wide = push_wide_q;
		end
	end
	////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [63:0] z(input logic [63:0] x);
		return {32'h0000_0000, x[31:0]};
	endfunction
	// One request; waits for handler entry or return, or checks that nothing starts
	task automatic fire(input bit quiet);
		int n;
		{tcnt, pops, ts, tr, n} = '0;
		pushes.delete();
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		while (!quiet && n < 300 && jump_q !== 1'b1 && resume_q !== 1'b1) begin
			@(negedge clk);
			n++;
		end
		if (quiet) repeat (4) @(negedge clk);
		if (quiet) check("idle", {busy_q, tcnt[7:0]}, 0);
		if (n == 300) check("done", 0, 1);
	endtask
	task automatic cmp;
		check("npush", pushes.size(), ex.size());
		foreach (ex[i]) check("push", pushes[i], ex[i]);
	endtask
	task automatic go(input exd_kind_e k, input logic [7:0] v, input logic [7:0] e);
		req.kind = k;
		req.vector = v;
		fire(0);
		check("vector", vector_q, e);
	endtask
	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{req_valid, tbl_valid, pop_valid, task_ack, tv, pv, av, stall} = '0;
		push_ready = 1'b1;
		pop_data = '0;
		req = '0;
		ent = '{G_TRAP, 2'd0, 1'b1, 16'h0030, 64'h0000_0000_0000_4000};
		tbl_entry = ent;
		mode = M_PROT;
		ctx = '{FL, CS[15:0], IP, SS[15:0], SP, 2'd0};
		nrst = 1'b0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		stall = 1'b1;
		go(K_INTN, 8'h40, 8'h40);
		check("addr", ta, 16'h0200);
		ex = '{z(FL), CS, z(IP)};
		cmp();
		check("cs", new_cs_q, 16'h0030);
		check("ip", new_ip_q, 64'h0000_0000_0000_4000);
		check("keep", new_flags_q[FLAG_IF], 1);
		ent.gtype = G_INTR;
		ctx.priv = 2'd3;
		req.err_valid = 1'b1;
		req.err_code = 32'h0000_0018;
		go(K_HW, 8'h0d, 8'h0d);
		ex = '{SS, z(SP), z(FL), CS, z(IP), 64'h0000_0000_0000_0018};
		cmp();
		check("clear", new_flags_q[31:0], 32'h0000_0802);
		req.err_valid = 1'b0;
		ctx.priv = 2'd0;
		mode = M_REAL;
		ent.off = 64'h0000_0000_2000_0100;
		go(K_INT3, 8'h77, VEC_BREAK);
		check("raddr", ta, 16'h000c);
		check("rcs", new_cs_q, 16'h2000);
		check("rip", new_ip_q[15:0], 16'h0100);
		ex = '{z(FL), CS, z(IP)};
		cmp();
		pq = '{64'h0000_0000_0000_1111, 64'h0000_0000_0000_2222, 64'h0000_0000_0000_0a02};
		req.kind = K_RETURN;
		fire(0);
		check("ret", {resume_q, pops[3:0]}, 5'h13);
		check("pip", new_ip_q, 64'h0000_0000_0000_1111);
		check("pcs", new_cs_q, 16'h2222);
		check("pfl", new_flags_q, 64'h0000_0000_0000_0a02);
		// Long mode, with and without a change of level
		mode = M_LONG;
		ent.gtype = G_TRAP;
		for (int c = 0; c < 2; c++) begin
			ctx.priv = c ? 2'd3 : 2'd0;
			go(K_INTN, 8'h04, VEC_OVF);
			ex = '{SS, SP, FL, CS, IP};
			cmp();
			check("wide", wide, 1);
			check("null", {ss_null_q, new_ss_q}, {c[0], c ? SEL_NULL : SS[15:0]});
		end
		// Long mode return takes five pops; flags come last
		pq = '{64'h0000_0000_0000_1111, 64'h0000_0000_0000_2222, 64'h0000_0000_0000_3333,
			64'h0000_0000_0000_4444, 64'h0000_0000_0000_0202};
		req.kind = K_RETURN;
		fire(0);
		check("lret", {resume_q, pops[3:0]}, 5'h15);
		check("lfl", new_flags_q, 64'h0000_0000_0000_0202);
		ctx.priv = 2'd0;
		ent.code64 = 1'b0;
		go(K_HW, 8'h21, VEC_GP);
		check("gaddr", ta, 16'h00d0);
		ent.code64 = 1'b1;
		mode = M_PROT;
		stall = 1'b0;
		go(K_INTO, 8'h00, VEC_OVF);
		go(K_HW, 8'h20, 8'h20);
		ctx.flags[FLAG_OVF] = 1'b0;
		req.kind = K_INTO;
		fire(1);
		req.bnd_lo = 32'h0000_0010;
		req.bnd_hi = 32'h0000_0020;
		req.kind = K_BOUND;
		for (int b = 0; b < 2; b++) begin
			req.bnd_val = b ? 32'h0000_0020 : 32'h0000_0010;
			fire(1);
		end
		req.bnd_val = 32'h0000_0021;
		go(K_BOUND, 8'h00, VEC_RANGE);
		go(K_HW, 8'h21, 8'h21);
		go(K_INTN, 8'h05, VEC_RANGE);
		for (int i = 0; i < FP_CONDS; i++) begin
			req.fp_cond = 6'h01 << i;
			go(K_FPX, 8'h00, VEC_FPERR);
			go(K_FPS, 8'h00, VEC_SIMDFP);
		end
		req.fp_cond = '0;
		req.kind = K_FPX;
		fire(1);
		ent = '{G_TASK, 2'd0, 1'b1, 16'h0028, 64'h0000_0000_0000_4000};
		go(K_HW, 8'h22, 8'h22);
		check("save", {ts[3:0], pushes.size()}, {4'h1, 32'h0});
		check("tsel", task_sel_q, 16'h0028);
		req.kind = K_RETURN;
		fire(0);
		check("restore", {resume_q, tr[3:0], pops[3:0]}, 9'h110);
		report_and_stop();
	end
	// Watchdog against a hang
	initial begin
		#250000;
		miscompares++;
		report_and_stop();
	end
endmodule
